// ### hdl/dcac_defines.svh
// constants of the dma channel arbitration and control block
// assumes one 20 MHz system clock and a single bus controller partner
//
// Notes on behaviour
// R1 - grant highest requester: 0A, 0B, 1A, 1B short; channel 0 before 1 full
// R2 - burst or block in progress keeps its channel until it finishes
// R3 - bus controller may suspend dma at unit boundaries for external cycles
// R4 - lower external masters are held off while dma owns the external bus
// R5 - dual address read and its write form one unit; release after write
// R6 - internal-target dma cycles proceed during external hold
// R7 - nmi clears master enable of full mode burst channels only
// R8 - full mode channel enabled only when xfer and master enable are both 1
// R9 - master enable cleared in burst: finish unit, stop, release bus
// R10 - setting master enable again resumes an interrupted burst
// R11 - clearing xfer or master enable stops after unit; setting resumes
// R12 - four interrupt outputs: sub-channel ends, or end and break per channel
// R13 - each source gated by its enable, separate line, 0A highest
// R14 - end interrupt is level: end enable 1 and xfer enable 0
// R15 - full mode break interrupt: master enable 0 and break enable 1
// R16 - software changes settings only with transfer disabled
// R17 - address presented one cycle ahead; address register updates then
// R18 - module stop refused while any channel enabled; stop freezes block
// R19 - interrupt, end pin and ack pin settings stay effective in stop
// R20 - write buffer lets next operation start during buffered write
// R21 - software alters external access registers only when idle
// R22 - cleared enable bit must be read as 0 before write of 1 works
// R23 - bus obtained by request and grant, held until release or preempt
`ifndef DCAC_DEFINES_SVH
`define DCAC_DEFINES_SVH

`define DCAC_NSUB        4
`define DCAC_NCH         2
`define DCAC_AW          16
`define DCAC_DW          16
`define DCAC_FIFO_DEPTH  16
`define DCAC_STEP_BYTE   16'h0001
`define DCAC_STEP_WORD   16'h0002
`define DCAC_TE_RST      4'h0
`define DCAC_ME_RST      2'h0
`define DCAC_ARM_RST     6'h3f
`define DCAC_MAR_RST     16'h0000

`endif

// ### hdl/dcac_pkg.sv
// types shared by the dma arbitration block and its test bench
// assumes the constants header is on the include path
`include "dcac_defines.svh"

package dcac_pkg;

  // software-visible enable bits: xfer enables per sub-channel, master per channel
  typedef struct packed {
    logic [`DCAC_NCH-1:0]  me;
    logic [`DCAC_NSUB-1:0] te;
  } dcac_en_t;

  typedef struct packed {
    logic burst;
    logic block;
    logic dual;
    logic ext;
    logic word;
    logic end_pin_enable_bit;
    logic single_addressing_enable_bit;
  } dcac_cfg_t;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [1:0]          sub;
    logic [`DCAC_AW-1:0] addr;
  } dcac_cyc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_RD   = 2'h3,
    ST_WR   = 2'h2
  } dcac_state_t;

endpackage

// ### hdl/dcac_mem.sv
// small storage array with registered read data
// assumes one write and one read port on the same clock
`timescale 1ns/1ps
`default_nettype none

module dcac_mem #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                 clock_in,
  input  wire logic                 wr_en_in,
  input  wire logic [$clog2(D)-1:0] wr_addr_in,
  input  wire logic [W-1:0]         wr_data_in,
  input  wire logic [$clog2(D)-1:0] rd_addr_in,
  output logic      [W-1:0]         rd_data_out
);

  logic [W-1:0] store_ff [D];

  always_ff @(posedge clock_in)
  begin
    if (wr_en_in)
    begin
      store_ff[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    rd_data_out <= store_ff[rd_addr_in];
  end

endmodule // dcac_mem

`default_nettype wire

// ### hdl/dcac_fifo.sv
// show-ahead fifo between bus read data and bus write data
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module dcac_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);

  localparam int AW = $clog2(D);

  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, rd_addr;
  logic [AW:0]   count_ff, nxt_count;
  logic          push, pop, head_ok_ff;

  assign in_ready_out  = (count_ff != (AW+1)'(D));
  assign out_valid_out = head_ok_ff;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & head_ok_ff;
  assign rd_addr       = pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff;

  always_comb
  begin
    nxt_count = count_ff;
    if (push & !pop)
    begin
      nxt_count = count_ff + (AW+1)'(1);
    end
    else if (pop & !push)
    begin
      nxt_count = count_ff - (AW+1)'(1);
    end
  end

  // head data lags a write by one edge, so a freshly written head waits
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      count_ff   <= '0;
      head_ok_ff <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      rd_ptr_ff  <= rd_addr;
      count_ff   <= nxt_count;
      head_ok_ff <= (nxt_count != '0) && !(push && wr_ptr_ff == rd_addr);
    end
  end

  dcac_mem #(.W(W), .D(D)) u_mem (
    .clock_in    (clock_in),
    .wr_en_in    (push),
    .wr_addr_in  (wr_ptr_ff),
    .wr_data_in  (in_data_in),
    .rd_addr_in  (rd_addr),
    .rd_data_out (out_data_out)
  );

endmodule // dcac_fifo

`default_nettype wire

// ### hdl/dcac_ctrl.sv
// two-channel dma arbitration, enable control, interrupts and stop lockout
// assumes a bus controller that grants the bus and flags completion of each bus cycle
`timescale 1ns/1ps
`default_nettype none

module dcac_ctrl (
  input  wire logic                          clock_in,
  input  wire logic                          resetn_in,
  input  wire logic                          sw_wr_in,
  input  wire dcac_pkg::dcac_en_t            sw_data_in,
  input  wire logic                          sw_rd_in,
  output dcac_pkg::dcac_en_t                 en_bits_out,
  input  wire dcac_pkg::dcac_cfg_t [3:0]     cfg_in,
  input  wire logic [1:0]                    full_in,
  input  wire logic [3:0]                    ie_in,
  input  wire logic [1:0]                    bie_in,
  input  wire logic                          wbuf_en_in,
  input  wire logic                          nmi_in,
  input  wire logic [3:0]                    req_in,
  input  wire logic                          stop_wr_in,
  input  wire logic                          stop_data_in,
  output logic                               stopped_out,
  input  wire logic                          mar_wr_in,
  input  wire logic [1:0]                    mar_sel_in,
  input  wire logic [15:0]                   mar_data_in,
  output logic                               bus_req_out,
  input  wire logic                          bus_gnt_in,
  output dcac_pkg::dcac_cyc_t                bus_cyc_out,
  input  wire logic                          bus_done_in,
  input  wire logic                          last_in,
  input  wire logic                          blk_end_in,
  input  wire logic [15:0]                   bus_rdata_in,
  output logic [15:0]                        bus_wdata_out,
  input  wire logic                          ext_hold_in,
  output logic                               cpu_ext_hold_out,
  output logic [3:0]                         irq_out,
  output logic [3:0]                         transfer_end_pin_pin_en_out,
  output logic [1:0]                         ack_pin_en_out
);
  import dcac_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] sub_enabled(dcac_en_t e, logic [1:0] f);
    logic [3:0] v;
    v = e.te;
    for (int c = 0; c < `DCAC_NCH; c++)
    begin
      if (f[c])
      begin
        v[2*c]   = e.te[2*c] & e.me[c]; // R8
        v[2*c+1] = 1'b0;
      end
    end
    return v;
  endfunction

  function automatic logic [1:0] pick_first(logic [3:0] r);
    logic [1:0] p;
    p = 2'h0;
    for (int i = `DCAC_NSUB-1; i >= 0; i--)
    begin
      if (r[i])
      begin
        p = 2'(i);
      end
    end
    return p;
  endfunction

  dcac_state_t     state_ff;
  dcac_en_t        en_ff, arm_ff, nxt_en, nxt_arm;
  dcac_cyc_t       cyc_ff;
  logic [15:0]     mar_ff [4];
  logic [3:0]      hold_ff, enabled, want, irq_ff, tee_ff;
  logic [1:0]      cur_ff, sel, ack_ff;
  logic            lock_ff, rel_ff, stop_ff, can_go, start, ext_blk;
  logic            wr_done, unit_done, keep, fifo_in_rdy, fifo_out_vld;
  logic [5:0]      hw_clr;
  dcac_cfg_t       ccfg;

  assign enabled = sub_enabled(en_ff, full_in);
  assign want    = enabled & (req_in | hold_ff);
  assign sel     = lock_ff ? cur_ff : pick_first(want); // R1 R2
  assign can_go  = lock_ff ? enabled[cur_ff] : |want;
  assign ccfg    = cfg_in[cur_ff];
  // internal targets ignore the external hold
  assign ext_blk = cfg_in[sel].ext & ext_hold_in; // R3 R6
  assign start   = state_ff == ST_IDLE && !stop_ff && !rel_ff && bus_gnt_in
                   && can_go && !ext_blk && fifo_in_rdy; // R23
  assign bus_req_out = !stop_ff && !rel_ff && (can_go || state_ff != ST_IDLE); // R23
  // buffered external write counts as done once issued
  assign wr_done   = state_ff == ST_WR && fifo_out_vld
                     && (bus_done_in || (wbuf_en_in && ccfg.ext)); // R20
  assign unit_done = (state_ff == ST_RD && bus_done_in && !ccfg.dual) || wr_done;
  assign keep      = ccfg.burst || (ccfg.block && !blk_end_in); // R2

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      state_ff <= ST_IDLE;
    end
    else if (!stop_ff)
    begin
      unique case (state_ff)
        ST_IDLE: if (start) state_ff <= ST_ADDR;
        ST_ADDR: state_ff <= ST_RD; // R17
        ST_RD:   if (bus_done_in) state_ff <= ccfg.dual ? ST_WR : ST_IDLE; // R5
        ST_WR:   if (wr_done) state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      cur_ff  <= 2'h0;
      lock_ff <= 1'b0;
      rel_ff  <= 1'b0;
      hold_ff <= 4'h0;
    end
    else
    begin
      rel_ff <= 1'b0;
      if (start)
      begin
        cur_ff          <= sel;
        hold_ff[sel]    <= 1'b0;
      end
      if (unit_done)
      begin
        lock_ff <= keep && !last_in;
        rel_ff  <= !(keep && !last_in); // R5
      end
      else if (state_ff == ST_IDLE && lock_ff && !enabled[cur_ff])
      begin
        // disabled mid burst: stop, give the bus back, resume later
        lock_ff         <= 1'b0; // R9 R11
        rel_ff          <= 1'b1;
        hold_ff[cur_ff] <= ccfg.burst; // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // bus cycle and address register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      cyc_ff <= '0;
    end
    else
    begin
      cyc_ff.valid <= !stop_ff && (state_ff == ST_ADDR || state_ff == ST_RD
                      && !bus_done_in || state_ff == ST_WR && !wr_done);
      cyc_ff.write <= state_ff == ST_RD && bus_done_in || state_ff == ST_WR;
      cyc_ff.sub   <= cur_ff;
      if (state_ff == ST_ADDR)
      begin
        cyc_ff.addr <= mar_ff[cur_ff];
      end
    end
  end
  assign bus_cyc_out = cyc_ff;

  // address moves on in the cycle ahead of the bus cycle
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `DCAC_NSUB; i++)
      begin
        mar_ff[i] <= `DCAC_MAR_RST;
      end
    end
    else if (!stop_ff)
    begin
      if (state_ff == ST_ADDR)
      begin
        mar_ff[cur_ff] <= mar_ff[cur_ff] + (ccfg.word ? `DCAC_STEP_WORD
                                                      : `DCAC_STEP_BYTE); // R17
      end
      else if (mar_wr_in)
      begin
        mar_ff[mar_sel_in] <= mar_data_in;
      end
    end
  end

  dcac_fifo #(.W(`DCAC_DW), .D(`DCAC_FIFO_DEPTH)) u_fifo (
    .clock_in      (clock_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (state_ff == ST_RD && bus_done_in && ccfg.dual),
    .in_ready_out  (fifo_in_rdy),
    .in_data_in    (bus_rdata_in),
    .out_valid_out (fifo_out_vld),
    .out_ready_in  (wr_done),
    .out_data_out  (bus_wdata_out)
  );

  assign cpu_ext_hold_out = (state_ff != ST_IDLE || lock_ff) && ccfg.ext; // R4

  // ----------------------------------------------------------------
  // enable bits
  // ----------------------------------------------------------------
  always_comb
  begin
    hw_clr = 6'h0;
    if (unit_done && last_in)
    begin
      hw_clr[cur_ff] = 1'b1;
    end
    for (int c = 0; c < `DCAC_NCH; c++)
    begin
      hw_clr[`DCAC_NSUB+c] = nmi_in && full_in[c] && cfg_in[2*c].burst; // R7
    end
    nxt_en = en_ff;
    if (sw_wr_in && !stop_ff)
    begin
      nxt_en = sw_data_in & (en_ff | arm_ff); // R11 R22
    end
    nxt_en  = nxt_en & ~hw_clr;
    nxt_arm = arm_ff & ~(en_ff & ~nxt_en);
    if (sw_rd_in && !stop_ff)
    begin
      nxt_arm = nxt_arm | ~en_ff; // R22
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      en_ff  <= {`DCAC_ME_RST, `DCAC_TE_RST};
      arm_ff <= `DCAC_ARM_RST;
    end
    else
    begin
      en_ff  <= nxt_en;
      arm_ff <= nxt_arm;
    end
  end
  assign en_bits_out = en_ff;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      stop_ff <= 1'b0;
    end
    else if (stop_wr_in)
    begin
      stop_ff <= stop_data_in ? (stop_ff || enabled == 4'h0) : 1'b0; // R18
    end
  end
  assign stopped_out = stop_ff;

  // ----------------------------------------------------------------
  // interrupts and pin enables, live even in stop
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      irq_ff <= 4'h0;
      tee_ff <= 4'h0;
      ack_ff <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < `DCAC_NCH; c++)
      begin
        irq_ff[2*c]   <= ie_in[2*c] && !en_ff.te[2*c]; // R12 R13 R14 R19
        irq_ff[2*c+1] <= full_in[c] ? bie_in[c] && !en_ff.me[c] // R15
                                    : ie_in[2*c+1] && !en_ff.te[2*c+1];
        ack_ff[c]     <= !full_in[c] && cfg_in[2*c].single_addressing_enable_bit; // R19
      end
      for (int i = 0; i < `DCAC_NSUB; i++)
      begin
        tee_ff[i] <= cfg_in[i].end_pin_enable_bit;
      end
    end
  end
  assign irq_out         = irq_ff;
  assign transfer_end_pin_pin_en_out = tee_ff;
  assign ack_pin_en_out  = ack_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_unit_start;
    state_ff == ST_IDLE && start;
  endsequence
  sequence s_addr_then_cycle;
    state_ff == ST_ADDR ##1 cyc_ff.valid;
  endsequence

  pick_highest_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R1
    s_unit_start and !lock_ff |=> cur_ff == $past(pick_first(want)))
    else $error("lower priority channel granted");
  lock_keeps_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R2
    lock_ff && start |=> cur_ff == $past(cur_ff))
    else $error("channel switched inside burst or block");
  ext_hold_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R3
    start |-> !(cfg_in[sel].ext && ext_hold_in))
    else $error("external unit started under hold");
  dual_unit_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R5
    state_ff == ST_RD && bus_done_in && ccfg.dual |=> state_ff == ST_WR && !rel_ff)
    else $error("bus released between read and write");
  nmi_clear_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R7
    nmi_in && full_in[0] && cfg_in[0].burst |=> !en_ff.me[0])
    else $error("nmi did not clear master enable");
  addr_ahead_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R17
    s_unit_start |=> s_addr_then_cycle ##0 cyc_ff.addr == $past(mar_ff[cur_ff], 1)
      ##0 mar_ff[cur_ff] != $past(mar_ff[cur_ff], 1))
    else $error("address register not updated ahead of cycle");
  stop_refuse_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R18
    stop_wr_in && stop_data_in && enabled != 4'h0 && !stop_ff |=> !stop_ff)
    else $error("module stop accepted while enabled");
  end_irq_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R14
    ie_in[0] && !en_ff.te[0] |=> irq_out[0])
    else $error("end interrupt missing");
  break_irq_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R15
    full_in[1] && bie_in[1] && !en_ff.me[1] |=> irq_out[3])
    else $error("break interrupt missing");
  rearm_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R22
    sw_wr_in && !stop_ff && !en_ff.te[1] && !arm_ff.te[1] && !hw_clr[1]
      |=> en_ff.te[1] == 1'b0)
    else $error("enable set without read of zero");
  stop_release_a: assert property (@(posedge clock_in) disable iff (!resetn_in) // R9
    state_ff == ST_IDLE && lock_ff && !enabled[cur_ff] && !unit_done
      |=> !lock_ff && rel_ff ##1 !bus_req_out || !rel_ff)
    else $error("disabled burst kept the bus");

endmodule // dcac_ctrl

`default_nettype wire

// ### sim/dcac_bus_model.sv
// bus controller model: grants on request, answers each dma cycle after a random wait
// assumes the dma block holds its cycle valid until it samples the done pulse
`timescale 1ns/1ps
`default_nettype none

module dcac_bus_model (
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  input  wire logic                bus_req_in,
  input  wire dcac_pkg::dcac_cyc_t bus_cyc_in,
  output logic                     bus_gnt_out,
  output logic                     bus_done_out,
  output logic [15:0]              bus_rdata_out
);
  import dcac_pkg::*;

  int         seed = 22778;
  logic [1:0] wait_ff;

  // ----------------------------------------
  // grant and answer
  // ----------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      bus_gnt_out   <= 1'b0;
      bus_done_out  <= 1'b0;
      bus_rdata_out <= 16'h5a5a;
      wait_ff       <= 2'h0;
    end
    else
    begin
      bus_gnt_out   <= bus_req_in;
      bus_done_out  <= 1'b0;
      // data line not valid outside done: keep it moving
      bus_rdata_out <= ~bus_rdata_out;
      if (bus_cyc_in.valid && !bus_done_out)
      begin
        if (wait_ff == 2'h0)
        begin
          bus_done_out <= 1'b1;
          {bus_rdata_out, wait_ff} <= 18'($random(seed));
        end
        else
          wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule // dcac_bus_model

`default_nettype wire

// ### sim/dcac_ctrl_test.sv
// self-checking bench for the dma arbitration and control block
// assumes the bus controller model in the same folder and the design package
`timescale 1ns/1ps
`default_nettype none

module dcac_ctrl_test;
  import dcac_pkg::*;

  logic            clock_in, resetn_in, nmi, last, ext_hold, gnt, done, req_o, wbuf;
  logic            stopped, cpu_hold, sw_wr, sw_rd, stop_wr, mar_wr, stop_data;
  logic [1:0]      full, bie, mar_sel, ack;
  logic [3:0]      ie, req, irq, transfer_end_pin_en, strb;
  logic [15:0]     mar_data, rdata, wdata, got, rd;
  logic [15:0]     memory_address_register [4];
  dcac_en_t        sw_data, en;
  dcac_cfg_t [3:0] cfg;
  dcac_cyc_t       cyc, seen;
  int              errors, samples_checked, cycles, seed, k;

  assign {mar_wr, stop_wr, sw_rd, sw_wr} = strb;

  dcac_ctrl dut_u (
    .clock_in(clock_in), .resetn_in(resetn_in), .sw_wr_in(sw_wr), .sw_data_in(sw_data),
    .sw_rd_in(sw_rd), .en_bits_out(en), .cfg_in(cfg), .full_in(full), .ie_in(ie),
    .bie_in(bie), .wbuf_en_in(wbuf), .nmi_in(nmi), .req_in(req), .stop_wr_in(stop_wr),
    .stop_data_in(stop_data), .stopped_out(stopped), .mar_wr_in(mar_wr),
    .mar_sel_in(mar_sel), .mar_data_in(mar_data), .bus_req_out(req_o), .bus_gnt_in(gnt),
    .bus_cyc_out(cyc), .bus_done_in(done), .last_in(last), .blk_end_in(1'b0),
    .bus_rdata_in(rdata), .bus_wdata_out(wdata), .ext_hold_in(ext_hold),
    .cpu_ext_hold_out(cpu_hold), .irq_out(irq), .transfer_end_pin_pin_en_out(transfer_end_pin_en),
    .ack_pin_en_out(ack)
  );

  dcac_bus_model bus_u (
    .clock_in(clock_in), .resetn_in(resetn_in), .bus_req_in(req_o), .bus_cyc_in(cyc),
    .bus_gnt_out(gnt), .bus_done_out(done), .bus_rdata_out(rdata)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic summarize;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // one-cycle strobe; ends at a falling edge so outputs are settled
  task automatic pulse(input logic [3:0] s, input logic [15:0] d, input logic [1:0] sel);
    tick(1);
    strb      <= s;
    sw_data   <= d[5:0];
    stop_data <= d[0];
    mar_data  <= d;
    mar_sel   <= sel;
    tick(1);
    strb      <= 4'h0;
    @(negedge clock_in);
  endtask

  task automatic sw_write(input logic [1:0] me, input logic [3:0] te);
    pulse(4'h1, {10'h0, me, te}, 2'h0);
  endtask

  task automatic wait_cyc;
    int i;
    for (i = 0; i < 300 && cyc.valid !== 1'b1; i++)
      @(negedge clock_in);
    check(i < 300, 1'b1);
    seen = cyc;
  endtask

  task automatic wait_done;
    int i;
    for (i = 0; i < 300 && done !== 1'b1; i++)
      @(negedge clock_in);
    check(i < 300, 1'b1);
    got = rdata;
    @(negedge clock_in);
  endtask

  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    seed = 22778;
    {sw_data, stop_data, mar_data, mar_sel, strb, nmi, req, ext_hold, full, wbuf} = '0;
    last = 1'b1;
    cfg = '0;
    ie = 4'($random(seed));
    bie = 2'($random(seed));
    for (k = 0; k < 4; k++)
      {cfg[k].end_pin_enable_bit, cfg[k].single_addressing_enable_bit} = 2'($random(seed));
    resetn_in = 1'b0;
    tick(16);
    resetn_in <= 1'b1;
    tick(2);
    @(negedge clock_in);
    check(irq, ie);
    // enable, stop lockout, rewrite arming
    sw_write(2'h0, 4'hf);
    pulse(4'h4, 16'h1, 2'h0);
    check(stopped, 1'b0);
    sw_write(2'h0, 4'h0);
    pulse(4'h4, 16'h1, 2'h0);
    check(stopped, 1'b1);
    check(irq, ie);
    check(transfer_end_pin_en, {cfg[3].end_pin_enable_bit, cfg[2].end_pin_enable_bit, cfg[1].end_pin_enable_bit, cfg[0].end_pin_enable_bit});
    check(ack, {cfg[2].single_addressing_enable_bit, cfg[0].single_addressing_enable_bit});
    sw_write(2'h0, 4'hf);
    check(en.te, 4'h0);
    pulse(4'h4, 16'h0, 2'h0);
    sw_write(2'h0, 4'hf);
    check(en.te, 4'h0);
    pulse(4'h2, 16'h0, 2'h0);
    // all four requesting at once: fixed order
    for (k = 0; k < 4; k++)
    begin
      memory_address_register[k] = 16'($random(seed));
      pulse(4'h8, memory_address_register[k], 2'(k));
    end
    tick(1);
    req <= 4'hf;
    ext_hold <= 1'b1;
    sw_write(2'h0, 4'hf);
    for (k = 0; k < 4; k++)
    begin
      wait_cyc();
      check(seen.sub, k);
      check(seen.addr, memory_address_register[k]);
      wait_done();
    end
    check(en.te, 4'h0);
    @(negedge clock_in);
    check(irq, ie);
    // burst on 0B keeps the bus against a later 0A request
    pulse(4'h2, 16'h0, 2'h0);
    memory_address_register[1] = 16'($random(seed));
    pulse(4'h8, memory_address_register[1], 2'h1);
    tick(1);
    cfg[1].burst <= 1'b1;
    cfg[1].word  <= 1'b1;
    req          <= 4'h2;
    last         <= 1'b0;
    sw_write(2'h0, 4'h3);
    for (k = 0; k < 3; k++)
    begin
      wait_cyc();
      check(seen.sub, 2'h1);
      check(seen.addr, memory_address_register[1] + 16'(2 * k));
      tick(1);
      req  <= 4'h3;
      last <= (k == 2);
      wait_done();
    end
    wait_cyc();
    check(seen.sub, 2'h0);
    check(seen.addr, memory_address_register[0] + 16'h1);
    wait_done();
    // full mode: both enables needed, nmi stops burst channel only
    tick(1);
    req          <= 4'h1;
    full         <= 2'h3;
    cfg[0].burst <= 1'b1;
    last         <= 1'b0;
    pulse(4'h2, 16'h0, 2'h0);
    sw_write(2'h0, 4'h5);
    tick(10);
    @(negedge clock_in);
    check(cyc.valid, 1'b0);
    check(irq[0], 1'b0);
    check({irq[3], irq[1]}, bie);
    sw_write(2'h3, 4'h5);
    wait_cyc();
    check(seen.sub, 2'h0);
    tick(1);
    nmi <= 1'b1;
    tick(1);
    nmi <= 1'b0;
    @(negedge clock_in);
    check(en.me, 2'h2);
    tick(10);
    @(negedge clock_in);
    check({req_o, cyc.valid}, 2'h0);
    check(irq[1], bie[0]);
    pulse(4'h2, 16'h0, 2'h0);
    sw_write(2'h3, 4'h5);
    wait_cyc();
    check(seen.sub, 2'h0);
    tick(1);
    last <= 1'b1;
    wait_done();
    check(en.te[0], 1'b0);
    sw_write(2'h0, 4'h0);
    // dual external transfer held off by the external bus
    tick(1);
    full     <= 2'h0;
    cfg[0]   <= '{burst: 1'b0, block: 1'b0, dual: 1'b1, ext: 1'b1,
                  word: 1'b0, end_pin_enable_bit: cfg[0].end_pin_enable_bit, single_addressing_enable_bit: 1'b0};
    ext_hold <= 1'b1;
    pulse(4'h2, 16'h0, 2'h0);
    sw_write(2'h0, 4'h1);
    tick(10);
    @(negedge clock_in);
    check(cyc.valid, 1'b0);
    tick(1);
    ext_hold <= 1'b0;
    wait_cyc();
    check(seen.write, 1'b0);
    check(cpu_hold, 1'b1);
    wait_done();
    rd = got;
    wait_cyc();
    check(seen.write, 1'b1);
    check(wdata, rd);
    wait_done();
    // buffered external write: counted done once issued, no answer awaited
    tick(1);
    wbuf <= 1'b1;
    pulse(4'h2, 16'h0, 2'h0);
    sw_write(2'h0, 4'h1);
    wait_done();
    rd = got;
    wait_cyc();
    check(seen.write, 1'b1);
    check(wdata, rd);
    @(negedge clock_in);
    check(cyc.valid, 1'b0);
    tick(4);
    @(negedge clock_in);
    check(en.te[0], 1'b0);
    summarize();
  end
endmodule // dcac_ctrl_test

`default_nettype wire
